/* hdl/sfdp_parameter_rom.sv */
`default_nettype none
// What this block does
// - byte 0Ah returns 01h table major
// - byte 0Bh returns 10h, sixteen dwords
// - bytes 0Ch..0Eh give pointer 30h,00h,00h
// - byte 0Fh returns FFh legacy id
// - byte 10h returns the maker code
// - bytes 11h/12h return 00h and 01h
// - byte 13h returns 03h, three dwords
// - bytes 14h..17h give 70h,00h,00h,FFh
// - byte 30h reads E5h, erase fields
// - byte 30h bit2 set, bits7:5 ones
// - byte 31h returns erase code 20h
// - byte 32h reads FBh read support flags
// - byte 32h bits18:17 read 01b
// - byte 33h returns FFh
// - bytes 34h..37h give density FFFFFF0Fh-order
// - byte 38h returns 44h quad-io cycles
// - reachable only by command 5Ah, from the address given with it
// - contents read-only, writes ignored
module sfdp_parameter_rom #(
  parameter logic [7:0] MAKER_CODE = sfdp_pkg::MAKER_CODE_DEFAULT
) (
  input  wire logic                         clk_in,
  input  wire logic                         rstn_in,
  input  wire logic                         start_in,
  input  wire logic [7:0]                   cmd_in,
  input  wire logic [sfdp_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic                         next_in,
  input  wire logic                         end_in,
  output logic                              busy_out,
  output logic                              valid_out,
  output logic [sfdp_pkg::DATA_W-1:0]       data_out,
  output logic [sfdp_pkg::ADDR_W-1:0]       addr_out
);

  sfdp_pkg::sfdp_state_t            state;
  sfdp_pkg::sfdp_state_t            next_state;
  logic [sfdp_pkg::ADDR_W-1:0]      addr;
  logic [sfdp_pkg::ADDR_W-1:0]      next_addr;
  logic                             valid;
  logic                             next_valid;
  logic [sfdp_pkg::DATA_W-1:0]      data;
  logic [sfdp_pkg::DATA_W-1:0]      next_data;
  logic [sfdp_pkg::DATA_W-1:0]      rom_byte;

  // depth of the byte space; addresses wrap at its top
  localparam int unsigned DEPTH = 2 ** sfdp_pkg::ADDR_W;

  // multi-field bytes are built from their fields so that each bit
  // group traces to its own constant rather than to a magic number
  logic [sfdp_pkg::DATA_W-1:0]      erase_byte;
  logic [sfdp_pkg::DATA_W-1:0]      reads_byte;
  logic [sfdp_pkg::DATA_W-1:0]      qio_byte;
  logic [sfdp_pkg::DATA_W-1:0]      table_mem [0:DEPTH-1];

  // byte 30h: unused bits, status default, buffer size, erase granule
  assign erase_byte = {sfdp_pkg::ERASE_UNUSED,
                       sfdp_pkg::ERASE_SR_NV,
                       sfdp_pkg::ERASE_BUF_GT,
                       sfdp_pkg::ERASE_4K_UNI};

  // byte 32h: read modes, transfer rate, address bytes, single/dual
  assign reads_byte = {sfdp_pkg::READS_UNUSED,
                       sfdp_pkg::QUAD_OUTPUT_READ,
                       sfdp_pkg::QUAD_IO_READ,
                       sfdp_pkg::DUAL_IO_READ,
                       sfdp_pkg::DOUBLE_RATE,
                       sfdp_pkg::ADDR_3_OR_4,
                       sfdp_pkg::SINGLE_LINE_IO};

  // byte 38h: mode cycles above dummy cycles
  assign qio_byte   = {sfdp_pkg::QIO_MODE_CYC,
                       sfdp_pkg::QIO_DUMMY_CYC};

  // header 0, first dword: only its upper two bytes are held here
  function automatic logic [7:0] ph0_dword1_byte(input logic [7:0] a);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_PH0_MAJOR: begin
        v = sfdp_pkg::V_PH0_MAJOR;
      end
      sfdp_pkg::A_PH0_LEN: begin
        v = sfdp_pkg::V_PH0_LEN;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : ph0_dword1_byte

  // header 0, second dword: basic table pointer and id high byte
  function automatic logic [7:0] ph0_dword2_byte(input logic [7:0] a);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_PH0_PTR0: begin
        v = sfdp_pkg::V_PH0_PTR0;
      end
      sfdp_pkg::A_PH0_PTR1: begin
        v = sfdp_pkg::V_ZERO;
      end
      sfdp_pkg::A_PH0_PTR2: begin
        v = sfdp_pkg::V_ZERO;
      end
      sfdp_pkg::A_PH0_ID_MSB: begin
        v = sfdp_pkg::V_FF;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : ph0_dword2_byte

  // header 1, first dword: maker code, revisions and length
  function automatic logic [7:0] ph1_dword1_byte(input logic [7:0] a,
                                                 input logic [7:0] maker);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_PH1_ID: begin
        v = maker;
      end
      sfdp_pkg::A_PH1_MINOR: begin
        v = sfdp_pkg::V_PH1_MINOR;
      end
      sfdp_pkg::A_PH1_MAJOR: begin
        v = sfdp_pkg::V_PH1_MAJOR;
      end
      sfdp_pkg::A_PH1_LEN: begin
        v = sfdp_pkg::V_PH1_LEN;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : ph1_dword1_byte

  // header 1, second dword: vendor table pointer and an unused byte
  function automatic logic [7:0] ph1_dword2_byte(input logic [7:0] a);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_PH1_PTR0: begin
        v = sfdp_pkg::V_PH1_PTR0;
      end
      sfdp_pkg::A_PH1_PTR1: begin
        v = sfdp_pkg::V_ZERO;
      end
      sfdp_pkg::A_PH1_PTR2: begin
        v = sfdp_pkg::V_ZERO;
      end
      sfdp_pkg::A_PH1_UNUSED: begin
        v = sfdp_pkg::V_FF;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : ph1_dword2_byte

  // basic table, first dword: erase and read capabilities
  function automatic logic [7:0] bft_dword1_byte(input logic [7:0] a,
                                                 input logic [7:0] erase,
                                                 input logic [7:0] reads);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_BFT_ERASE: begin
        v = erase;
      end
      sfdp_pkg::A_BFT_ER_CODE: begin
        v = sfdp_pkg::V_BFT_ER_CODE;
      end
      sfdp_pkg::A_BFT_READS: begin
        v = reads;
      end
      sfdp_pkg::A_BFT_UNUSED: begin
        v = sfdp_pkg::V_FF;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : bft_dword1_byte

  // basic table, second dword: zero-based density, low byte first
  function automatic logic [7:0] bft_dword2_byte(input logic [7:0] a);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_BFT_DENS0: begin
        v = sfdp_pkg::V_FF;
      end
      sfdp_pkg::A_BFT_DENS1: begin
        v = sfdp_pkg::V_FF;
      end
      sfdp_pkg::A_BFT_DENS2: begin
        v = sfdp_pkg::V_FF;
      end
      sfdp_pkg::A_BFT_DENS3: begin
        v = sfdp_pkg::V_DENS3;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : bft_dword2_byte

  // basic table, third dword: only its first byte is held here
  function automatic logic [7:0] bft_dword3_byte(input logic [7:0] a,
                                                 input logic [7:0] quad_io_read);
    logic [7:0] v;
    case (a)
      sfdp_pkg::A_BFT_QIO_CYC: begin
        v = quad_io_read;
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : bft_dword3_byte

  // one entry of the table: the dword by the upper bits, then the byte
  function automatic logic [7:0] rom_lookup(input logic [7:0] a,
                                            input logic [7:0] maker,
                                            input logic [7:0] erase,
                                            input logic [7:0] reads,
                                            input logic [7:0] quad_io_read);
    logic [7:0] v;
    case (a[7:2])
      sfdp_pkg::A_PH0_MAJOR[7:2]: begin
        v = ph0_dword1_byte(a);
      end
      sfdp_pkg::A_PH0_PTR0[7:2]: begin
        v = ph0_dword2_byte(a);
      end
      sfdp_pkg::A_PH1_ID[7:2]: begin
        v = ph1_dword1_byte(a, maker);
      end
      sfdp_pkg::A_PH1_PTR0[7:2]: begin
        v = ph1_dword2_byte(a);
      end
      sfdp_pkg::A_BFT_ERASE[7:2]: begin
        v = bft_dword1_byte(a, erase, reads);
      end
      sfdp_pkg::A_BFT_DENS0[7:2]: begin
        v = bft_dword2_byte(a);
      end
      sfdp_pkg::A_BFT_QIO_CYC[7:2]: begin
        v = bft_dword3_byte(a, quad_io_read);
      end
      default: begin
        v = sfdp_pkg::V_UNCOVERED;
      end
    endcase
    return v;
  endfunction : rom_lookup

  // the table is a constant array with no write path, so no host
  // action can change what it returns
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    assign table_mem[i] = rom_lookup(8'(i), MAKER_CODE, erase_byte,
                                     reads_byte, qio_byte);
  end

  // the address spans the whole space, so every index is in range
  assign rom_byte = table_mem[addr];

  always_comb begin
    next_state = state;
    next_addr  = addr;
    next_valid = 1'b0;
    next_data  = data;
    case (state)
      sfdp_pkg::SFDP_IDLE: begin
        // any other command code leaves the table untouched and silent
        if (start_in && cmd_in == sfdp_pkg::READ_DISCOVERY_PARAMS_CMD) begin
          next_state = sfdp_pkg::SFDP_READ;
          next_addr  = addr_in;
        end
      end
      sfdp_pkg::SFDP_READ: begin
        if (end_in) begin
          next_state = sfdp_pkg::SFDP_IDLE;
        end else if (next_in) begin
          // address wraps within the 256-byte space
          next_data  = rom_byte;
          next_valid = 1'b1;
          next_addr  = addr + 8'h01;
        end
      end
      default: begin
        next_state = sfdp_pkg::SFDP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state <= sfdp_pkg::SFDP_IDLE;
      addr  <= 8'h00;
      valid <= 1'b0;
      data  <= 8'h00;
    end else begin
      state <= next_state;
      addr  <= next_addr;
      valid <= next_valid;
      data  <= next_data;
    end
  end

  assign busy_out  = (state == sfdp_pkg::SFDP_READ);
  assign valid_out = valid;
  assign data_out  = data;
  assign addr_out  = addr;

endmodule : sfdp_parameter_rom
`default_nettype wire

/* hdl/sfdp_pkg.sv */
`default_nettype none
package sfdp_pkg;
  // byte address width of the parameter space (0000h..00ffh)
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // command code that opens the parameter space
  localparam logic [7:0] READ_DISCOVERY_PARAMS_CMD = 8'h5a;

  // arbitrary neutral value for the second table's maker code
  localparam logic [7:0] MAKER_CODE_DEFAULT = 8'ha5;

  // byte addresses
  localparam logic [7:0] A_PH0_MAJOR   = 8'h0a;
  localparam logic [7:0] A_PH0_LEN     = 8'h0b;
  localparam logic [7:0] A_PH0_PTR0    = 8'h0c;
  localparam logic [7:0] A_PH0_PTR1    = 8'h0d;
  localparam logic [7:0] A_PH0_PTR2    = 8'h0e;
  localparam logic [7:0] A_PH0_ID_MSB  = 8'h0f;
  localparam logic [7:0] A_PH1_ID      = 8'h10;
  localparam logic [7:0] A_PH1_MINOR   = 8'h11;
  localparam logic [7:0] A_PH1_MAJOR   = 8'h12;
  localparam logic [7:0] A_PH1_LEN     = 8'h13;
  localparam logic [7:0] A_PH1_PTR0    = 8'h14;
  localparam logic [7:0] A_PH1_PTR1    = 8'h15;
  localparam logic [7:0] A_PH1_PTR2    = 8'h16;
  localparam logic [7:0] A_PH1_UNUSED  = 8'h17;
  localparam logic [7:0] A_BFT_ERASE   = 8'h30;
  localparam logic [7:0] A_BFT_ER_CODE = 8'h31;
  localparam logic [7:0] A_BFT_READS   = 8'h32;
  localparam logic [7:0] A_BFT_UNUSED  = 8'h33;
  localparam logic [7:0] A_BFT_DENS0   = 8'h34;
  localparam logic [7:0] A_BFT_DENS1   = 8'h35;
  localparam logic [7:0] A_BFT_DENS2   = 8'h36;
  localparam logic [7:0] A_BFT_DENS3   = 8'h37;
  localparam logic [7:0] A_BFT_QIO_CYC = 8'h38;

  // data values
  localparam logic [7:0] V_PH0_MAJOR   = 8'h01;
  localparam logic [7:0] V_PH0_LEN     = 8'h10;
  localparam logic [7:0] V_PH0_PTR0    = 8'h30;
  localparam logic [7:0] V_ZERO        = 8'h00;
  localparam logic [7:0] V_FF          = 8'hff;
  localparam logic [7:0] V_PH1_MINOR   = 8'h00;
  localparam logic [7:0] V_PH1_MAJOR   = 8'h01;
  localparam logic [7:0] V_PH1_LEN     = 8'h03;
  localparam logic [7:0] V_PH1_PTR0    = 8'h70;
  localparam logic [7:0] V_BFT_ER_CODE = 8'h20;
  localparam logic [7:0] V_DENS3       = 8'h0f;

  // byte 30h fields
  localparam logic [2:0] ERASE_UNUSED  = 3'h7;
  localparam logic [1:0] ERASE_SR_NV   = 2'h0;
  localparam logic       ERASE_BUF_GT  = 1'b1;
  localparam logic [1:0] ERASE_4K_UNI  = 2'h1;

  // byte 32h fields
  localparam logic       READS_UNUSED     = 1'b1;
  localparam logic       QUAD_OUTPUT_READ = 1'b1;
  localparam logic       QUAD_IO_READ     = 1'b1;
  localparam logic       DUAL_IO_READ     = 1'b1;
  localparam logic       DOUBLE_RATE      = 1'b1;
  localparam logic [1:0] ADDR_3_OR_4      = 2'h1;
  localparam logic       SINGLE_LINE_IO   = 1'b1;

  // byte 38h fields
  localparam logic [2:0] QIO_MODE_CYC  = 3'h2;
  localparam logic [4:0] QIO_DUMMY_CYC = 5'h04;

  // value returned for locations outside the covered span
  localparam logic [7:0] V_UNCOVERED   = 8'hff;

  typedef enum logic [0:0] {
    SFDP_IDLE = 1'b0,
    SFDP_READ = 1'b1
  } sfdp_state_t;
endpackage : sfdp_pkg
`default_nettype wire

/* tb/sfdp_rom_assertions.sv */
`default_nettype none
module sfdp_rom_assertions (
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       start_in,
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] addr_in,
  input wire logic       next_in,
  input wire logic       end_in,
  input wire logic       busy_out,
  input wire logic       valid_out,
  input wire logic [7:0] data_out,
  input wire logic [7:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic tk = busy_out && next_in && !end_in;
  wire logic go = !busy_out && start_in;
  open_sess_a: assert property (go && cmd_in == 8'h5a |=> busy_out
    && addr_out == $past(addr_in)) else $error("session did not open");
  bad_cmd_a: assert property (go && cmd_in != 8'h5a |=> !busy_out)
    else $error("wrong command opened a session");
  byte_ans_a: assert property (tk |=> valid_out)
    else $error("byte request not answered");
  no_spur_a: assert property (!tk |=> !valid_out)
    else $error("byte returned without request");
  addr_step_a: assert property (tk |=>
    addr_out == $past(addr_out) + 8'h01) else $error("address did not step");
  data_hold_a: assert property (!valid_out |-> $stable(data_out))
    else $error("data changed between bytes");
  close_sess_a: assert property (busy_out && end_in |=> !busy_out)
    else $error("session did not close");
  erase_byte_a: assert property (valid_out && $past(addr_out) == 8'h30
    |-> data_out == 8'he5) else $error("erase byte wrong");
  cover property (tk ##1 tk);
  cover property (go && cmd_in != 8'h5a);
  cover property (busy_out && end_in);
  cover property (busy_out && start_in);
endmodule : sfdp_rom_assertions
`default_nettype wire

/* tb/sfdp_host_model.sv */
`default_nettype none
module sfdp_host_model (
  input  wire logic       clk_in,
  input  wire logic       busy_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] data_in,
  output logic            start_out,
  output logic [7:0]      cmd_out,
  output logic [7:0]      addr_out,
  output logic            next_out,
  output logic            end_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [0:31];
  logic       vld [0:31];
  int         nvalid;
  logic       opened;
  initial begin
    {start_out, next_out, end_out, cmd_out, addr_out} = '0;
  end
  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input int n);
    nvalid = 0;
    @(negedge clk_in);
    start_out = 1'b1;
    cmd_out = c;
    addr_out = a;
    @(negedge clk_in);
    start_out = 1'b0;
    // stale lines flip so a held value never looks like a fresh request
    cmd_out = ~c;
    addr_out = ~a;
    opened = busy_in;
    for (int i = 0; i < n; i++) begin
      next_out = 1'b1;
      @(negedge clk_in);
      got[i] = data_in;
      vld[i] = valid_in;
      nvalid += int'(valid_in);
    end
    next_out = 1'b0;
    end_out = 1'b1;
    @(negedge clk_in);
    end_out = 1'b0;
  endtask : xfer
  // opens at a0, raises start again at a1 while busy, then takes one byte
  task automatic stray(input logic [7:0] a0, input logic [7:0] a1);
    @(negedge clk_in);
    start_out = 1'b1;
    cmd_out = 8'h5a;
    addr_out = a0;
    @(negedge clk_in);
    addr_out = a1;
    @(negedge clk_in);
    start_out = 1'b0;
    next_out = 1'b1;
    @(negedge clk_in);
    next_out = 1'b0;
    got[0] = data_in;
    vld[0] = valid_in;
  endtask : stray
endmodule : sfdp_host_model
`default_nettype wire

/* tb/sfdp_parameter_rom_tb_top.sv */
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module sfdp_parameter_rom_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary maker code
  logic       clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       start_in, next_in, end_in, busy_out, valid_out;
  logic [7:0] cmd_in, addr_in, data_out, addr_out;
  int         err_count = 0;
  int         samples_checked = 0;
  always #4 clk_in = ~clk_in;
  sfdp_parameter_rom #(.MAKER_CODE(MAKER)) u_sfdp_parameter_rom (.clk_in,
    .rstn_in, .start_in, .cmd_in, .addr_in, .next_in, .end_in, .busy_out,
    .valid_out, .data_out, .addr_out);
  sfdp_host_model u_sfdp_host_model (.clk_in, .busy_in(busy_out),
    .valid_in(valid_out), .data_in(data_out), .start_out(start_in),
    .cmd_out(cmd_in), .addr_out(addr_in), .next_out(next_in),
    .end_out(end_in));
  function automatic logic [7:0] rom(input logic [7:0] a);
    logic [111:0] hdr = {8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff, MAKER,
      8'h00, 8'h01, 8'h03, 8'h70, 8'h00, 8'h00, 8'hff};
    logic [71:0] bft = {8'he5, 8'h20, 8'hfb, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h0f, 8'h44};
    if (a >= 8'h0a && a <= 8'h17) return hdr[8*(8'h17-a) +: 8];
    if (a >= 8'h30 && a <= 8'h38) return bft[8*(8'h38-a) +: 8];
    return 8'hff;
  endfunction : rom
  task automatic run(input string nm, input logic [7:0] a, input int n);
    u_sfdp_host_model.xfer(8'h5a, a, n);
    `CHK("opened", 1'b1, u_sfdp_host_model.opened)
    `CHK("count", n, u_sfdp_host_model.nvalid)
    for (int i = 0; i < n; i++) begin
      `CHK(nm, rom(a + i[7:0]), u_sfdp_host_model.got[i])
      `CHK("valid", 1'b1, u_sfdp_host_model.vld[i])
    end
    $display("test %s done", nm);
  endtask : run
  task automatic t_header();
    run("header", 8'h0a, 14);
  endtask : t_header
  task automatic t_basic();
    run("basic", 8'h2e, 12);
  endtask : t_basic
  task automatic t_wrap();
    run("wrap", 8'hff, 12);
  endtask : t_wrap
  task automatic t_reread();
    run("reread", 8'h0b, 2);
  endtask : t_reread
  task automatic t_refuse();
    u_sfdp_host_model.xfer(8'h03, 8'h0a, 2);
    `CHK("refused open", 1'b0, u_sfdp_host_model.opened)
    `CHK("refused bytes", 0, u_sfdp_host_model.nvalid)
    for (int i = 0; i < 2; i++) begin
      `CHK("refused valid", 1'b0, u_sfdp_host_model.vld[i])
    end
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_reset();
    u_sfdp_host_model.stray(8'h30, 8'h0a);
    `CHK("restart byte", 8'he5, u_sfdp_host_model.got[0])
    `CHK("restart valid", 1'b1, u_sfdp_host_model.vld[0])
    `CHK("restart addr", 8'h31, addr_out)
    // session left open: a mid-run reset must close it
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    `CHK("reset busy", 1'b0, busy_out)
    `CHK("reset valid", 1'b0, valid_out)
    `CHK("reset data", 8'h00, data_out)
    `CHK("reset addr", 8'h00, addr_out)
    rstn_in = 1'b1;
    $display("test reset done");
  endtask : t_reset
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(negedge clk_in);
    rstn_in = 1'b1;
    t_refuse();
    t_header();
    t_basic();
    t_wrap();
    t_reset();
    t_reread();
    final_report();
  end
endmodule : sfdp_parameter_rom_tb_top
bind sfdp_parameter_rom sfdp_rom_assertions u_sfdp_rom_assertions (.clk_in,
  .rstn_in, .start_in, .cmd_in, .addr_in, .next_in, .end_in, .busy_out,
  .valid_out, .data_out, .addr_out);
`default_nettype wire
